/* File: verilog/i2c_mode_ctrl.sv */
// I2C mode-control block: registers, master byte engine, loopback.
// Assumes one AHB-Lite master, open-drain pins with external pull-ups,
// and software that keeps the loopback and free-format restrictions.
//
// Design decisions made here: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/10ps
module i2c_mode_ctrl
  import i2c_mode_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave port
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Interrupt
  output logic irq,
  // I2C pins
  input wire logic scl_in,
  input wire logic sda_in,
  output i2c_drive_t pins_drive
);

  // Whole state of the block, bar the bit timer's counter
  typedef struct packed {
    logic [1:0] scl_sync;  // Pin synchronisers
    logic [1:0] sda_sync;
    logic [7:0] addr_q;    // Data-phase address
    logic wr_q;            // Data-phase write pending
    logic rdy;             // Bus ready, never stalls
    logic resp;            // Always OKAY
    logic [31:0] rdata;    // Read data for the data phase
    logic [15:0] mode;     // Mode control register
    logic [9:0] target;    // Target address register
    logic [9:0] own;       // Own address register
    logic [15:0] count;    // Byte count register
    logic [15:0] remain;   // Bytes still to move
    logic [7:0] txd;       // Transmit data register
    logic [7:0] rxd;       // Receive data register
    logic tx_full;         // Transmit data waiting
    logic [3:0] status;    // Sticky events
    logic [3:0] mask;      // Interrupt mask
    logic irq;             // Registered interrupt
    state_t state;         // Engine state
    stage_t stage;         // Byte kind on the wire
    logic [1:0] phase;     // Quarter within a bit
    logic [3:0] bitn;      // Bit within a byte, 8 is ack
    logic [7:0] shreg;     // Outgoing byte
    logic [7:0] rxsh;      // Incoming byte
    logic last;            // Receiver answers this byte with no-ack
    logic nack;            // Ack slot sampled high
    logic halt;            // Peer refused; only stop or restart
    logic waited;          // Access ready already raised
    i2c_drive_t drive;     // Pin drive
  } core_t;

  core_t st;
  core_t next_st;
  logic tick;     // Quarter-bit strobe
  logic [3:0] ev; // Events raised this cycle
  logic bit_in;   // Sampled data bit
  logic more;     // Transfer may go on
  logic rpt;      // Repeat mode in force

  // Register read decode, shared by every read
  function automatic logic [31:0] read_reg(input core_t s, input logic [7:0] a);
    if (a == MODE_OFS) begin
      return {16'h0000, s.mode};
    end else if (a == TARGET_OFS) begin
      return {22'h000000, s.target};
    end else if (a == OWN_OFS) begin
      return {22'h000000, s.own};
    end else if (a == COUNT_OFS) begin
      return {16'h0000, s.count};
    end else if (a == TXD_OFS) begin
      return {24'h000000, s.txd};
    end else if (a == RXD_OFS) begin
      return {24'h000000, s.rxd};
    end else if (a == STATUS_OFS) begin
      return {28'h0000000, s.status};
    end else if (a == MASK_OFS) begin
      return {28'h0000000, s.mask};
    end else begin
      // Unmapped offsets read as zero
      return 32'h00000000;
    end
  endfunction : read_reg

  // Address to send, used for both address bytes
  function automatic logic [9:0] addr_src(input core_t s);
    // RQ11 loopback sends own
    // RQ3 ten-bit uses own
    if (s.mode[LOOP_BIT] || s.mode[XA_BIT]) begin
      return s.own;
    end else begin
      // RQ2 seven-bit target
      return s.target;
    end
  endfunction : addr_src

  // First byte of an address
  function automatic logic [7:0] first_byte(input core_t s);
    logic [9:0] a;
    a = addr_src(s);
    if (s.mode[XA_BIT]) begin
      // RQ3 ten-bit header
      return {TEN_BIT_PREFIX, a[9:8], 1'b0};
    end else begin
      // RQ2 seven bits plus R/W
      return {a[6:0], ~s.mode[DIR_BIT]};
    end
  endfunction : first_byte

  // Shared bit clock for transmit and receive
  bit_timer u_timer (
    .hclk(hclk),
    .hresetn(hresetn),
    .enable(st.mode[RUN_BIT] && (st.state != S_IDLE || st.mode[START_BIT])),
    .tick(tick)
  );

  // Next-state logic for bus, registers and engine
  always_comb begin
    next_st = st;
    ev = 4'h0;
    bit_in = 1'b1;
    // RQ4 repeat only as transmitter
    rpt = st.mode[REPEAT_BIT] && st.mode[DIR_BIT];
    // RQ5 counted transfer length
    // RQ6 repeat ignores count
    more = rpt || (st.remain != 16'h0000);
    next_st.rdy = 1'b1;
    next_st.resp = 1'b0;
    // Two-flop synchronisers on the pins
    next_st.scl_sync = {st.scl_sync[0], scl_in};
    next_st.sda_sync = {st.sda_sync[0], sda_in};

    // Data phase of a write, zero wait states
    if (st.wr_q) begin
      if (st.addr_q == MODE_OFS) begin
        // RQ17 software alone sets mode
        next_st.mode = hwdata[15:0] & MODE_WMASK;
        // RQ15 start, stop locked when stopped
        if (!st.mode[RUN_BIT]) begin
          next_st.mode[START_BIT] = st.mode[START_BIT];
          next_st.mode[STOP_BIT] = st.mode[STOP_BIT];
        end
      end else if (st.addr_q == TARGET_OFS) begin
        next_st.target = hwdata[9:0];
      end else if (st.addr_q == OWN_OFS) begin
        next_st.own = hwdata[9:0];
      end else if (st.addr_q == COUNT_OFS) begin
        next_st.count = hwdata[15:0];
      end else if (st.addr_q == TXD_OFS) begin
        // RQ6 each write queues one byte
        next_st.txd = hwdata[7:0];
        next_st.tx_full = 1'b1;
      end else if (st.addr_q == STATUS_OFS) begin
        // Write one to clear
        next_st.status = st.status & ~hwdata[3:0];
      end else if (st.addr_q == MASK_OFS) begin
        next_st.mask = hwdata[3:0];
      end
    end

    // Address phase: latch, and fetch read data a cycle early
    next_st.wr_q = 1'b0;
    if (hsel && htrans[1] && hready) begin
      next_st.addr_q = haddr[7:0];
      next_st.wr_q = hwrite;
      if (!hwrite) begin
        next_st.rdata = read_reg(st, haddr[7:0]);
      end
    end

    // Engine, stepped once per quarter bit
    if (st.mode[RUN_BIT] && tick) begin
      case (st.state)
        S_IDLE: begin
          // Start only as master
          if (st.mode[START_BIT] && st.mode[MASTER_BIT]) begin
            next_st.state = S_START;
            next_st.phase = 2'h0;
          end
        end
        S_START: begin
          // Works from idle and as repeated start with SCL low
          next_st.phase = st.phase + 2'h1;
          if (st.phase == 2'h0) begin
            next_st.drive.sda_oe = 1'b0;
          end else if (st.phase == 2'h1) begin
            next_st.drive.scl_oe = 1'b0;
          end else if (st.phase == 2'h2) begin
            next_st.drive.sda_oe = 1'b1;
          end else begin
            next_st.drive.scl_oe = 1'b1;
            next_st.mode[START_BIT] = 1'b0;
            next_st.state = S_SHIFT;
            next_st.stage = G_ADDR_HI;
            next_st.shreg = first_byte(st);
            next_st.remain = st.count;
            next_st.bitn = 4'h0;
            next_st.halt = 1'b0;
            next_st.waited = 1'b0;
          end
        end
        S_SHIFT: begin
          next_st.phase = st.phase + 2'h1;
          if (st.phase == 2'h0) begin
            // RQ1 direction picks who drives
            if (st.bitn != 4'h8) begin
              if (st.stage != G_DATA || st.mode[DIR_BIT]) begin
                next_st.drive.sda_oe = ~st.shreg[7];
              end else begin
                next_st.drive.sda_oe = 1'b0;
              end
            end else if (st.stage == G_DATA && !st.mode[DIR_BIT]) begin
              // Receiver acks, or no-acks the last counted byte
              next_st.drive.sda_oe = ~st.last;
            end else begin
              next_st.drive.sda_oe = 1'b0;
            end
          end else if (st.phase == 2'h1) begin
            next_st.drive.scl_oe = 1'b0;
          end else if (st.phase == 2'h2 && !st.scl_sync[1]) begin
            // A peer stretching SCL holds the sample quarter until the line rises
            next_st.phase = st.phase;
          end else if (st.phase == 2'h2) begin
            // RQ9 loopback reads own drive
            if (st.mode[LOOP_BIT]) begin
              bit_in = ~st.drive.sda_oe;
            end else begin
              bit_in = st.sda_sync[1];
            end
            if (st.bitn != 4'h8) begin
              next_st.rxsh = {st.rxsh[6:0], bit_in};
            end else begin
              next_st.nack = bit_in && !st.mode[LOOP_BIT];
            end
          end else begin
            next_st.drive.scl_oe = 1'b1;
            next_st.shreg = {st.shreg[6:0], 1'b0};
            next_st.bitn = st.bitn + 4'h1;
            if (st.bitn == 4'h8) begin
              next_st.bitn = 4'h0;
              if (st.stage == G_ADDR_HI && st.mode[XA_BIT]) begin
                // RQ3 second ten-bit byte
                next_st.stage = G_ADDR_LO;
                next_st.shreg = 8'(addr_src(st));
              end else begin
                next_st.state = S_HOLD;
                next_st.stage = G_DATA;
                if (st.stage == G_DATA) begin
                  next_st.remain = st.remain - 16'h0001;
                  // RQ9 byte lands in receive register
                  if (!st.mode[DIR_BIT] || st.mode[LOOP_BIT]) begin
                    next_st.rxd = st.rxsh;
                    ev[RX_READY_BIT] = 1'b1;
                  end
                end
                // A byte refused while transmitting ends the data flow, bar the first ten-bit address byte
                if (st.nack && st.mode[DIR_BIT]) begin
                  ev[NO_ACK_BIT] = 1'b1;
                  next_st.halt = 1'b1;
                end
              end
            end
          end
        end
        S_HOLD: begin
          // SCL stays low while software supplies data or a decision
          next_st.drive.sda_oe = 1'b0;
          next_st.phase = 2'h0;
          if (!st.halt && more && st.mode[DIR_BIT] && st.tx_full) begin
            // RQ6 send the queued byte
            next_st.state = S_SHIFT;
            next_st.shreg = st.txd;
            // A byte written in this very cycle stays queued, so it is not lost
            next_st.tx_full = st.wr_q && (st.addr_q == TXD_OFS);
            next_st.waited = 1'b0;
            ev[TX_READY_BIT] = 1'b1;
          end else if (!st.halt && more && !st.mode[DIR_BIT]) begin
            next_st.state = S_SHIFT;
            next_st.last = (st.remain == 16'h0001);
          end else if (st.mode[STOP_BIT]) begin
            next_st.state = S_STOP;
          end else if (st.mode[START_BIT]) begin
            next_st.state = S_START;
          end else if (!st.waited) begin
            // RQ7 ready for data or stop
            ev[ACCESS_READY_BIT] = 1'b1;
            next_st.waited = 1'b1;
          end
        end
        S_STOP: begin
          next_st.phase = st.phase + 2'h1;
          if (st.phase == 2'h0) begin
            next_st.drive.sda_oe = 1'b1;
          end else if (st.phase == 2'h1) begin
            next_st.drive.scl_oe = 1'b0;
          end else if (st.phase == 2'h2) begin
            next_st.drive.sda_oe = 1'b0;
          end else begin
            // RQ16 stop ends master role
            next_st.mode[MASTER_BIT] = 1'b0;
            next_st.mode[STOP_BIT] = 1'b0;
            next_st.mode[START_BIT] = 1'b0;
            next_st.state = S_IDLE;
          end
        end
        default: begin
          next_st.state = S_IDLE;
        end
      endcase
    end

    // Events win over a clear in the same cycle
    next_st.status = next_st.status | ev;

    // RQ13 held in reset, status defaults
    // RQ14 pins released when enabled
    if (!st.mode[RUN_BIT]) begin
      next_st.state = S_IDLE;
      next_st.status = STATUS_RESET;
      next_st.tx_full = 1'b0;
      next_st.halt = 1'b0;
      next_st.waited = 1'b0;
      next_st.drive = '0;
    end

    // Outputs are never driven high, only released
    next_st.drive.scl_out = 1'b0;
    next_st.drive.sda_out = 1'b0;
    next_st.irq = |(next_st.status & next_st.mask);
  end

  // The single state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Every output is a flop
  assign hreadyout = st.rdy;
  assign hresp = st.resp;
  assign hrdata = st.rdata;
  assign irq = st.irq;
  assign pins_drive = st.drive;

endmodule : i2c_mode_ctrl

/* File: include/i2c_mode_pkg.sv */
// Constants, types and register map of the I2C mode-control block.
// Assumes a single 200 MHz clock and an AHB-Lite register port.
// Operation
// RQ1: Direction bit: 0 receive, 1 transmit.
// RQ2: Seven-bit mode uses address bits 6-0.
// RQ3: Ten-bit mode uses own address bits 9-0.
// RQ4: Repeat applies only as master transmitter.
// RQ5: Counted mode moves exactly count bytes.
// RQ6: Repeat mode sends per write until stop.
// RQ7: Repeat mode raises access ready when waiting.
// RQ8: Loopback needs master select set by software.
// RQ9: Loopback returns sent data to receive register.
// RQ10: Loopback shares one timing source both ways.
// RQ11: Loopback sends own address, not target.
// RQ12: Software never mixes free format with loopback.
// RQ13: Run bit low holds reset, clears status.
// RQ14: Run bit high enables, releases bus lines.
// RQ15: Start and stop ignore writes while stopped.
// RQ16: Master select clears when stop is generated.
// RQ17: Mode bits keep written values until rewritten; the engine clears start, stop and master select itself.
package i2c_mode_pkg;

  // Register byte offsets
  localparam logic [7:0] MODE_OFS = 8'h00;
  localparam logic [7:0] TARGET_OFS = 8'h04;
  localparam logic [7:0] OWN_OFS = 8'h08;
  localparam logic [7:0] COUNT_OFS = 8'h0C;
  localparam logic [7:0] TXD_OFS = 8'h10;
  localparam logic [7:0] RXD_OFS = 8'h14;
  localparam logic [7:0] STATUS_OFS = 8'h18;
  localparam logic [7:0] MASK_OFS = 8'h1C;

  // Mode register field positions
  localparam int START_BIT = 13;
  localparam int STOP_BIT = 11;
  localparam int MASTER_BIT = 10;
  localparam int DIR_BIT = 9;
  localparam int XA_BIT = 8;
  localparam int REPEAT_BIT = 7;
  localparam int LOOP_BIT = 6;
  localparam int RUN_BIT = 5;
  localparam int FREE_BIT = 3;
  // Implemented, writable mode bits; the rest read as zero
  localparam logic [15:0] MODE_WMASK = 16'h2FE8;

  // Status and mask field positions
  localparam int ACCESS_READY_BIT = 0;
  localparam int RX_READY_BIT = 1;
  localparam int TX_READY_BIT = 2;
  localparam int NO_ACK_BIT = 3;

  // Reset values and the ten-bit address prefix
  localparam logic [15:0] MODE_RESET = 16'h0000;
  localparam logic [3:0] STATUS_RESET = 4'h0;
  localparam logic [4:0] TEN_BIT_PREFIX = 5'h1E;

  // Timing: one quarter of an SCL bit at 100 kHz
  localparam int CLK_PERIOD_NS = 5;
  localparam int SCL_QUARTER_NS = 2500;
  localparam logic [9:0] QUARTER_CYCLES = 10'(SCL_QUARTER_NS / CLK_PERIOD_NS);

  // Engine states
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_START = 3'b001,
    S_SHIFT = 3'b010,
    S_HOLD = 3'b011,
    S_STOP = 3'b100
  } state_t;

  // Which byte of a transfer is on the wire
  typedef enum logic [1:0] {
    G_ADDR_HI = 2'b00,
    G_ADDR_LO = 2'b01,
    G_DATA = 2'b10
  } stage_t;

  // Open-drain pin drive, enable high while pulling low
  typedef struct packed {
    logic scl_out;
    logic scl_oe;
    logic sda_out;
    logic sda_oe;
  } i2c_drive_t;

endpackage : i2c_mode_pkg

/* File: verilog/bit_timer.sv */
// Quarter-bit tick generator for the I2C engine.
// Assumes the engine holds enable high for the length of a transfer.
`timescale 1ns/10ps
module bit_timer
  import i2c_mode_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control and tick
  input wire logic enable,
  output logic tick
);

  // Counter state
  typedef struct packed {
    logic [9:0] cnt; // Cycles into the current quarter
    logic tick;      // One-cycle quarter strobe
  } timer_t;

  timer_t st;
  timer_t next_st;

  // RQ10 one shared timebase
  // Send and receive both step on this tick, so loopback is self-timed
  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (!enable) begin
      next_st.cnt = 10'h000;
    end else if (st.cnt == QUARTER_CYCLES - 10'h001) begin
      next_st.cnt = 10'h000;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 10'h001;
    end
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick = st.tick;

endmodule : bit_timer

/* File: tb/i2c_mode_asserts.sv */
// Port-level checker for the I2C mode-control block.
// Assumes one clock domain and a single AHB-Lite master.
`timescale 1ns/10ps
module i2c_mode_asserts
  import i2c_mode_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // Interrupt and pins
  input wire logic irq,
  input wire i2c_drive_t pins_drive
);
  // Mode bits that only software may change
  localparam logic [15:0] KEEP_MASK = 16'h03E8;
  logic take; // Address phase accepted
  logic mode_wr; // Mode write now in data phase
  logic [15:0] mode_copy; // Last mode value written
  logic [2:0] off_cnt; // Cycles with run bit low, saturating
  logic [9:0] gap; // Cycles since SCL drive last changed

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  assign take = hsel && htrans[1] && hready;

  // Shadow of the mode register; the counter lets a soft reset settle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_wr <= 1'b0;
      mode_copy <= 16'h0000;
      off_cnt <= 3'h0;
      gap <= 10'h3FF;
    end else begin
      mode_wr <= take && hwrite && (haddr[7:0] == MODE_OFS);
      if (mode_wr) begin
        mode_copy <= hwdata[15:0];
      end
      if (mode_copy[RUN_BIT]) begin
        off_cnt <= 3'h0;
      end else if (off_cnt != 3'h7) begin
        off_cnt <= off_cnt + 3'h1;
      end
      // Saturates so an idle bus never looks like a short quarter
      if ($changed(pins_drive.scl_oe)) begin
        gap <= 10'h000;
      end else if (gap != 10'h3FF) begin
        gap <= gap + 10'h001;
      end
    end
  end

  a_ready_high: assert property ($past(hresetn) |-> hreadyout)
    else $error("Bus stalled after reset");
  a_resp_okay: assert property (!hresp)
    else $error("Error response seen");
  a_drive_low_only: assert property (!pins_drive.scl_out && !pins_drive.sda_out)
    else $error("Pin driven high");
  a_unmapped_zero: assert property (take && !hwrite && haddr[7:0] > MASK_OFS
    |=> hrdata == 32'h0) else $error("Unmapped read not zero");
  a_mode_keep: assert property (take && !hwrite && haddr[7:0] == MODE_OFS
    |=> hrdata[31:16] == 16'h0000
    && (hrdata[15:0] & KEEP_MASK) == ($past(mode_copy) & KEEP_MASK))
    else $error("Mode bits changed by hardware");
  a_irq_quiet: assert property (off_cnt >= 3'h4 |-> !irq)
    else $error("Interrupt while disabled");
  a_bus_free: assert property (off_cnt >= 3'h4 |-> !pins_drive.scl_oe && !pins_drive.sda_oe)
    else $error("Bus held while disabled");
  a_quarter_gap: assert property (mode_copy[RUN_BIT] && $changed(pins_drive.scl_oe)
    |-> gap >= QUARTER_CYCLES - 10'h001) else $error("SCL phase too short");
endmodule : i2c_mode_asserts

bind i2c_mode_ctrl i2c_mode_asserts u_asserts (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .irq(irq), .pins_drive(pins_drive)
);

/* File: tb/i2c_target_model.sv */
// Behavioural I2C target that acknowledges every byte.
// Assumes open-drain lines with pull-ups resolved by the bench.
`timescale 1ns/10ps
module i2c_target_model (
  // Bus lines
  input wire logic scl,
  input wire logic sda,
  // Acknowledge pull and the address byte seen
  output logic ack_pull,
  output logic [7:0] first_byte
);
  int bit_n = 0; // Bits clocked in this byte
  int byte_n = 0; // Bytes since the last start
  logic [7:0] shift = 8'h00; // Incoming byte, MSB first

  initial begin
    ack_pull = 1'b0;
    first_byte = 8'h00;
  end

  // Start: data falls while clock is released
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      bit_n = 0;
      byte_n = 0;
    end
  end

  // Sample on clock high; the ninth pulse is the acknowledge slot
  always @(posedge scl) begin
    if (bit_n < 8) begin
      shift = {shift[6:0], sda};
    end
    bit_n++;
  end

  // Change the pull only while the clock is low, so no false start or stop
  always @(negedge scl) begin
    if (bit_n == 8) begin
      ack_pull <= 1'b1;
      if (byte_n == 0) begin
        first_byte <= shift;
      end
      byte_n++;
    end else if (bit_n == 9) begin
      ack_pull <= 1'b0;
      bit_n = 0;
    end
  end
endmodule : i2c_target_model

/* File: tb/testbench.sv */
// Self-checking bench for the I2C mode-control block.
// Assumes the checker is bound in and the target model sits on the pins.
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin miscompares++; \
  $display("[ERR] t=%0t got %h exp %h", $time, (a), (b)); end end
module testbench
  import i2c_mode_pkg::*;
;
  logic hclk = 1'b0; // 200 MHz clock
  logic hresetn = 1'b0; // Active-low reset
  logic hsel = 1'b1; // Only slave on the bus
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2; // Word transfers only
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, irq;
  logic [31:0] hrdata;
  logic [31:0] rd; // Last word read
  i2c_drive_t pins_drive;
  logic scl, sda, ack_pull;
  logic [7:0] first_byte;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;

  always #2.5 hclk = ~hclk;
  // Open-drain lines with pull-ups
  assign scl = ~pins_drive.scl_oe;
  assign sda = ~(pins_drive.sda_oe | ack_pull);

  i2c_mode_ctrl dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .irq(irq), .scl_in(scl), .sda_in(sda), .pins_drive(pins_drive));
  i2c_target_model partner (.scl(scl), .sda(sda), .ack_pull(ack_pull),
    .first_byte(first_byte));

  task automatic complete_run();
    if (miscompares == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run

  // Hang guard, well above one loopback transfer
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 95000) begin
      miscompares++;
      complete_run();
    end
  end

  // One single transfer; the leading edge keeps reads off a write's data phase
  task automatic bus_xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
    @(posedge hclk);
    htrans <= 2'h2;
    haddr <= {24'h0, addr};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wdata;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus_xfer

  task automatic t_reset_values();
    bus_xfer(1'b0, MODE_OFS, 32'h0);
    `CHK(rd, {16'h0000, MODE_RESET})
    bus_xfer(1'b0, STATUS_OFS, 32'h0);
    `CHK(rd, {28'h0, STATUS_RESET})
    `CHK({irq, pins_drive}, 5'h00)
    bus_xfer(1'b1, 8'h40, 32'hFFFF);
    bus_xfer(1'b0, 8'h40, 32'h0);
    `CHK(rd, 32'h0)
  endtask : t_reset_values

  // Start and stop refused while the run bit is low
  task automatic t_start_gated();
    bus_xfer(1'b1, MODE_OFS, 32'h2C00);
    bus_xfer(1'b0, MODE_OFS, 32'h0);
    `CHK(rd, 32'h1 << MASTER_BIT)
    bus_xfer(1'b1, MODE_OFS, 32'h2020);
    bus_xfer(1'b0, MODE_OFS, 32'h0);
    `CHK(rd, 32'h1 << RUN_BIT)
    repeat (600) @(posedge hclk);
    `CHK(pins_drive, 4'h0)
  endtask : t_start_gated

  // The direction, ten-bit, repeat and free-format mode fields each hold their written value
  task automatic t_mode_fields();
    int pos [4] = '{DIR_BIT, XA_BIT, REPEAT_BIT, FREE_BIT};
    for (int i = 0; i < 4; i++) begin
      bus_xfer(1'b1, MODE_OFS, (32'h1 << RUN_BIT) | (32'h1 << pos[i]));
      bus_xfer(1'b0, MODE_OFS, 32'h0);
      `CHK(rd, (32'h1 << RUN_BIT) | (32'h1 << pos[i]))
    end
  endtask : t_mode_fields

  // One counted loopback byte, then interrupt mask, clear and soft reset
  task automatic t_loopback();
    bus_xfer(1'b1, OWN_OFS, 32'h2D);
    bus_xfer(1'b1, TARGET_OFS, 32'h55);
    bus_xfer(1'b1, COUNT_OFS, 32'h1);
    bus_xfer(1'b1, TXD_OFS, 32'hAA);
    bus_xfer(1'b1, MASK_OFS, 32'hF);
    bus_xfer(1'b1, MODE_OFS, 32'h20);
    bus_xfer(1'b1, MODE_OFS, 32'h2E60);
    rd = 32'h1 << MASTER_BIT;
    while (rd[MASTER_BIT] !== 1'b0) bus_xfer(1'b0, MODE_OFS, 32'h0);
    `CHK(rd, 32'h0260)
    `CHK(first_byte, 8'h5A)
    `CHK({scl, sda}, 2'b11)
    bus_xfer(1'b0, RXD_OFS, 32'h0);
    `CHK(rd, 32'hAA)
    bus_xfer(1'b0, STATUS_OFS, 32'h0);
    `CHK(rd, (32'h1 << RX_READY_BIT) | (32'h1 << TX_READY_BIT))
    `CHK(irq, 1'b1)
    bus_xfer(1'b1, MASK_OFS, 32'h0);
    bus_xfer(1'b0, MASK_OFS, 32'h0);
    `CHK(irq, 1'b0)
    bus_xfer(1'b1, MASK_OFS, 32'hF);
    bus_xfer(1'b1, STATUS_OFS, 32'h1 << RX_READY_BIT);
    bus_xfer(1'b0, STATUS_OFS, 32'h0);
    `CHK(rd[RX_READY_BIT], 1'b0)
    bus_xfer(1'b1, MODE_OFS, 32'h0240);
    repeat (2) @(posedge hclk);
    bus_xfer(1'b0, STATUS_OFS, 32'h0);
    `CHK({irq, rd}, 33'h0)
  endtask : t_loopback

  // Main sequence
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset_values();
    t_start_gated();
    t_mode_fields();
    t_loopback();
    complete_run();
  end
endmodule : testbench
